/* File: logic/sil_top.sv */
// Status latches, interrupt enables and active-low interrupt output behind the serial port
// How it works
// [R1] Synthesizer lock-loss enable 0x68 bit 5 lets its latched flag pull interrupt low.
// [R2] VCXO lock-loss enable 0x68 bit 4 lets its latched flag pull interrupt low.
// [R3] Enables 0x68 bits 3..0 let each input's latched loss flag pull interrupt low.
// [R4] Reference enable 0x69 bit 1 interrupts on any reference change, not only loss.
// [R5] Holdover enable 0x69 bit 0 lets its latched flag pull interrupt low.
// [R6] All enables reset to zero; a disabled flag never affects the interrupt.
// [R7] Latched synthesizer flag holds loss events, reading 0 after any, else 1.
// [R8] Writing 1 clears the synthesizer latch and its pending interrupt; software acknowledges.
// [R9] Latched synthesizer flag derives from live status, readable at 0x6d.
// [R10] Two-bit field reports input in use by selection logic, codes 00 to 11.
// [R11] Latched reference flag reads 0 after loss, 1 if valid; write 1 clears.
// [R12] Latched holdover flag reads 0 after holdover entry, else 1; write 1 clears.
// [R13] Live input bits read 1 while active, feed latched flags cleared by writing 1.
// [R14] Interrupt output is inverted OR of enabled pending flags, low until all cleared.
// [R15] Live status sampled on register clock; a set beats a coincident clear.
`timescale 1ns/100ps
module sil_top
    import sil_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe,
    input wire logic synth_lock_loss_live_n,
    input wire logic vcxo_lock_loss_live_n,
    input wire logic [SIL_NUM_INPUTS-1:0] input_active_live,
    input wire logic [1:0] selected_input_code,
    input wire logic reference_present_live,
    input wire logic holdover_live_n,
    input wire logic synth_calibration_active,
    output logic irq_out_n
);

    // ********************************
    // Declarations
    // ********************************
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic [7:0] reg_rdata;
    logic [10:0] status_meta;
    logic [10:0] status_sync;
    logic synth_lock_ok;
    logic vcxo_lock_ok;
    logic [SIL_NUM_INPUTS-1:0] input_active;
    logic [1:0] selected_code;
    logic reference_present;
    logic holdover_ok;
    logic calibration_active;
    logic reference_prev;
    logic reference_change;
    logic [SIL_LOCK_GROUP_WIDTH-1:0] lock_irq_en;
    logic [SIL_REF_GROUP_WIDTH-1:0] ref_irq_en;
    logic [SIL_LOCK_GROUP_WIDTH-1:0] lock_fault;
    logic [SIL_LOCK_GROUP_WIDTH-1:0] lock_clear;
    logic [SIL_LOCK_GROUP_WIDTH-1:0] lock_pending;
    logic [SIL_REF_GROUP_WIDTH-1:0] ref_fault;
    logic [SIL_REF_GROUP_WIDTH-1:0] ref_clear;
    logic [SIL_REF_GROUP_WIDTH-1:0] ref_pending;
    logic ref_change_pending;
    logic next_irq;

    // ********************************
    // Serial port
    // ********************************
    sil_spi_slave u_spi (
        .ref_clk(ref_clk),
        .rst(rst),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_sdio_in(spi_sdio_in),
        .spi_sdio_out(spi_sdio_out),
        .spi_sdio_oe(spi_sdio_oe),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rdata(reg_rdata)
    );

    // ********************************
    // Live status synchronisers
    // ********************************
    // [R15] sample on register clock
    // Select code bits cross independently; a read during a switch may mix codes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_meta <= 11'h000;
            status_sync <= 11'h000;
        end else begin
            status_meta <= {synth_lock_loss_live_n, vcxo_lock_loss_live_n, input_active_live,
                selected_input_code, reference_present_live, holdover_live_n,
                synth_calibration_active};
            status_sync <= status_meta;
        end
    end

    assign synth_lock_ok = status_sync[10];
    assign vcxo_lock_ok = status_sync[9];
    assign input_active = status_sync[8:5];
    // [R10] selected input report
    assign selected_code = status_sync[4:3];
    assign reference_present = status_sync[2];
    assign holdover_ok = status_sync[1];
    assign calibration_active = status_sync[0];

    // ********************************
    // Interrupt enables
    // ********************************
    // [R6] enables reset to zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lock_irq_en <= SIL_LOCK_IRQ_EN_RESET;
        end else if (reg_wr && reg_addr == SIL_ADDR_PLL_AND_INPUT_IRQ_ENABLE) begin
            lock_irq_en <= reg_wdata[SIL_LOCK_GROUP_WIDTH-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ref_irq_en <= SIL_REF_IRQ_EN_RESET;
        end else if (reg_wr && reg_addr == SIL_ADDR_REF_AND_HOLDOVER_IRQ_ENABLE) begin
            ref_irq_en <= reg_wdata[SIL_REF_GROUP_WIDTH-1:0];
        end
    end

    // ********************************
    // Latched flags
    // ********************************
    // [R9] latch fed from live lock status
    // [R13] input loss feeds its latch
    assign lock_fault = {~synth_lock_ok, ~vcxo_lock_ok, ~input_active};
    // [R8] write one clears latch
    assign lock_clear = (reg_wr && reg_addr == SIL_ADDR_LATCHED_LOCK_AND_INPUT_FLAGS) ?
        reg_wdata[SIL_LOCK_GROUP_WIDTH-1:0] : 6'h00;

    // [R7] hold lock-loss events
    sil_sticky_flag #(
        .WIDTH(SIL_LOCK_GROUP_WIDTH)
    ) u_lock_flags (
        .ref_clk(ref_clk),
        .rst(rst),
        .fault(lock_fault),
        .clear(lock_clear),
        .pending(lock_pending)
    );

    // [R11] reference loss latched
    // [R12] holdover entry latched
    assign ref_fault = {~reference_present, ~holdover_ok};
    assign ref_clear = (reg_wr && reg_addr == SIL_ADDR_LATCHED_REF_HOLDOVER_FLAGS) ?
        reg_wdata[SIL_REF_GROUP_WIDTH-1:0] : 2'h0;

    sil_sticky_flag #(
        .WIDTH(SIL_REF_GROUP_WIDTH)
    ) u_ref_flags (
        .ref_clk(ref_clk),
        .rst(rst),
        .fault(ref_fault),
        .clear(ref_clear),
        .pending(ref_pending)
    );

    // ********************************
    // Reference change tracking
    // ********************************
    // Recovery also counts as a change, so software learns when the reference returns
    assign reference_change = reference_present ^ reference_prev;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reference_prev <= 1'b0;
        end else begin
            reference_prev <= reference_present;
        end
    end

    // [R4] any change is an event
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ref_change_pending <= 1'b0;
        end else if (reference_change) begin
            ref_change_pending <= 1'b1;
        end else if (ref_clear[SIL_BIT_REFERENCE]) begin
            ref_change_pending <= 1'b0;
        end
    end

    // ********************************
    // Interrupt output
    // ********************************
    // [R1] synthesizer lock source
    // [R2] VCXO lock source
    // [R3] input loss sources
    // [R5] holdover source
    // [R14] inverted OR of enabled flags
    always_comb begin
        next_irq = |(lock_irq_en & lock_pending);
        if (ref_irq_en[SIL_BIT_REFERENCE] && ref_change_pending) begin
            next_irq = 1'b1;
        end
        if (ref_irq_en[SIL_BIT_HOLDOVER] && ref_pending[SIL_BIT_HOLDOVER]) begin
            next_irq = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_out_n <= 1'b1;
        end else begin
            irq_out_n <= ~next_irq;
        end
    end

    // ********************************
    // Read data
    // ********************************
    // Latches read inverted: 0 means an event was seen since the last clear
    always_comb begin
        reg_rdata = SIL_UNMAPPED_READ;
        unique case (reg_addr)
            SIL_ADDR_PLL_AND_INPUT_IRQ_ENABLE: begin
                reg_rdata = {2'h0, lock_irq_en};
            end
            SIL_ADDR_REF_AND_HOLDOVER_IRQ_ENABLE: begin
                reg_rdata = {6'h00, ref_irq_en};
            end
            SIL_ADDR_LATCHED_LOCK_AND_INPUT_FLAGS: begin
                reg_rdata = {2'h0, ~lock_pending};
            end
            SIL_ADDR_LIVE_LOCK_INPUT_SELECT_STATUS: begin
                reg_rdata = {selected_code, synth_lock_ok, vcxo_lock_ok, input_active};
            end
            SIL_ADDR_LATCHED_REF_HOLDOVER_FLAGS: begin
                reg_rdata = {6'h00, ~ref_pending};
            end
            SIL_ADDR_LIVE_REF_HOLDOVER_CAL_STATUS: begin
                reg_rdata = {5'h00, calibration_active, reference_present, holdover_ok};
            end
            default: begin
                reg_rdata = SIL_UNMAPPED_READ;
            end
        endcase
    end

endmodule

/* File: logic/sil_pkg.sv */
// Package of register map, field layout and reset values for the status and interrupt logic
package sil_pkg;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [6:0] SIL_ADDR_PLL_AND_INPUT_IRQ_ENABLE = 7'h68;
    localparam logic [6:0] SIL_ADDR_REF_AND_HOLDOVER_IRQ_ENABLE = 7'h69;
    localparam logic [6:0] SIL_ADDR_LATCHED_LOCK_AND_INPUT_FLAGS = 7'h6c;
    localparam logic [6:0] SIL_ADDR_LIVE_LOCK_INPUT_SELECT_STATUS = 7'h6d;
    localparam logic [6:0] SIL_ADDR_LATCHED_REF_HOLDOVER_FLAGS = 7'h6e;
    localparam logic [6:0] SIL_ADDR_LIVE_REF_HOLDOVER_CAL_STATUS = 7'h6f;

    // ********************************
    // Field positions
    // ********************************
    localparam int SIL_NUM_INPUTS = 4;
    localparam int SIL_BIT_INPUT_LSB = 0;
    localparam int SIL_BIT_VCXO_LOCK = 4;
    localparam int SIL_BIT_SYNTH_LOCK = 5;
    localparam int SIL_BIT_SELECT_LSB = 6;
    localparam int SIL_BIT_HOLDOVER = 0;
    localparam int SIL_BIT_REFERENCE = 1;
    localparam int SIL_BIT_CALIBRATION = 2;
    localparam int SIL_LOCK_GROUP_WIDTH = 6;
    localparam int SIL_REF_GROUP_WIDTH = 2;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [5:0] SIL_LOCK_IRQ_EN_RESET = 6'h00;
    localparam logic [1:0] SIL_REF_IRQ_EN_RESET = 2'h0;
    localparam logic [7:0] SIL_UNMAPPED_READ = 8'h00;

    // ********************************
    // Serial frame layout
    // ********************************
    localparam logic [4:0] SIL_SPI_HEADER_BITS = 5'h08;
    localparam logic [4:0] SIL_SPI_FRAME_BITS = 5'h10;
    localparam int SIL_SPI_READ_BIT = 7;

    typedef enum logic [1:0] {
        SIL_PHASE_HEADER,
        SIL_PHASE_READ,
        SIL_PHASE_WRITE,
        SIL_PHASE_DONE
    } sil_phase_type;

endpackage

/* File: logic/sil_sticky_flag.sv */
// Sticky event flags with write-one-to-clear, set winning over clear
`timescale 1ns/100ps
module sil_sticky_flag
    import sil_pkg::*;
#(
    parameter int WIDTH = 6
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] fault,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] pending
);

    // ********************************
    // Per-flag latch
    // ********************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            // [R15] set beats clear
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    pending[i] <= 1'b0;
                end else if (fault[i]) begin
                    pending[i] <= 1'b1;
                end else if (clear[i]) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

/* File: logic/sil_spi_slave.sv */
// Three-wire serial configuration port slave, oversampled on the register clock
`timescale 1ns/100ps
module sil_spi_slave
    import sil_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    input wire logic [7:0] reg_rdata
);

    // ********************************
    // Pin synchronisers
    // ********************************
    logic [2:0] sclk_meta;
    logic [2:0] sclk_sync;
    logic sclk_prev;
    logic [4:0] bit_count;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic load_read;
    sil_phase_type phase;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_active;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sclk_meta <= 3'h7;
            sclk_sync <= 3'h7;
            sclk_prev <= 1'b1;
        end else begin
            sclk_meta <= {spi_sclk, spi_cs_n, spi_sdio_in};
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync[2];
        end
    end

    assign sclk_rise = sclk_sync[2] & ~sclk_prev;
    assign sclk_fall = ~sclk_sync[2] & sclk_prev;
    assign frame_active = ~sclk_sync[1];

    // ********************************
    // Frame sequencing
    // ********************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_count <= 5'h00;
            shift_in <= 8'h00;
            phase <= SIL_PHASE_HEADER;
            reg_addr <= 7'h00;
            reg_wdata <= 8'h00;
            reg_wr <= 1'b0;
            load_read <= 1'b0;
        end else begin
            reg_wr <= 1'b0;
            load_read <= 1'b0;
            if (!frame_active) begin
                bit_count <= 5'h00;
                phase <= SIL_PHASE_HEADER;
            end else if (sclk_rise && phase != SIL_PHASE_DONE) begin
                shift_in <= {shift_in[6:0], sclk_sync[0]};
                bit_count <= bit_count + 5'h01;
                if (bit_count == SIL_SPI_HEADER_BITS - 5'h01) begin
                    reg_addr <= {shift_in[5:0], sclk_sync[0]};
                    if (shift_in[SIL_SPI_READ_BIT - 1]) begin
                        phase <= SIL_PHASE_READ;
                        load_read <= 1'b1;
                    end else begin
                        phase <= SIL_PHASE_WRITE;
                    end
                end else if (bit_count == SIL_SPI_FRAME_BITS - 5'h01) begin
                    phase <= SIL_PHASE_DONE;
                    if (phase == SIL_PHASE_WRITE) begin
                        reg_wdata <= {shift_in[6:0], sclk_sync[0]};
                        reg_wr <= 1'b1;
                    end
                end
            end
        end
    end

    // ********************************
    // Read data return
    // ********************************
    // Data is launched on falling edges so the host samples it on the next rise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shift_out <= 8'h00;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe <= 1'b0;
        end else if (!frame_active) begin
            spi_sdio_oe <= 1'b0;
            spi_sdio_out <= 1'b0;
        end else if (load_read) begin
            shift_out <= reg_rdata;
        end else if (sclk_fall && phase == SIL_PHASE_READ) begin
            spi_sdio_out <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
            spi_sdio_oe <= 1'b1;
        end else if (sclk_fall && phase == SIL_PHASE_DONE) begin
            spi_sdio_oe <= 1'b0;
        end
    end

endmodule

/* File: testbench/sil_host_model.sv */
// Host processor model driving serial register frames
`timescale 1ns/100ps
module sil_host_model (
    input wire logic ref_clk,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_sdio_in,
    input wire logic spi_sdio_out,
    input wire logic spi_sdio_oe
);
    logic host_bit = 1'b0;
    logic host_en = 1'b0;
    logic idle_bit = 1'b0;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
    end

    // Released line toggles so a stale value is never read back as data
    // Kept apart from the driven bit so the frame task never races this process
    always @(negedge ref_clk) begin
        idle_bit <= ~idle_bit;
    end
    assign spi_sdio_in = spi_sdio_oe ? spi_sdio_out : (host_en ? host_bit : idle_bit);

    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [15:0] frame;
        frame = {rd, a, wd};
        rdat = 8'h00;
        @(negedge ref_clk);
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            host_en = !(rd && i < 8);
            if (host_en) begin
                host_bit = frame[i];
            end
            repeat (5) @(negedge ref_clk);
            spi_sclk = 1'b1;
            if (i < 8) begin
                rdat[i] = spi_sdio_in;
            end
            repeat (5) @(negedge ref_clk);
            spi_sclk = 1'b0;
        end
        host_en = 1'b0;
        repeat (3) @(negedge ref_clk);
        spi_cs_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask
endmodule

/* File: testbench/sil_top_monitor.sv */
// Checker of interrupt pin and serial port timing
`timescale 1ns/100ps
module sil_top_monitor
    import sil_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdio_in,
    input wire logic spi_sdio_out,
    input wire logic spi_sdio_oe,
    input wire logic synth_lock_loss_live_n,
    input wire logic vcxo_lock_loss_live_n,
    input wire logic [SIL_NUM_INPUTS-1:0] input_active_live,
    input wire logic [1:0] selected_input_code,
    input wire logic reference_present_live,
    input wire logic holdover_live_n,
    input wire logic synth_calibration_active,
    input wire logic irq_out_n
);
    logic [4:0] calm;
    logic [4:0] since_frame;
    logic ref_seen;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ********************************
    // Cycles since a cause of interrupt change
    // ********************************
    always_ff @(posedge ref_clk) begin
        ref_seen <= reference_present_live;
    end
    always_ff @(posedge ref_clk) begin
        if (rst || !spi_cs_n || !synth_lock_loss_live_n || !vcxo_lock_loss_live_n
            || input_active_live != 4'hf || !holdover_live_n
            || ref_seen != reference_present_live) begin
            calm <= 5'h00;
        end else if (calm != 5'h1f) begin
            calm <= calm + 5'h01;
        end
    end
    // Only a write frame may release the pin, so count from frame activity
    always_ff @(posedge ref_clk) begin
        if (rst || !spi_cs_n) begin
            since_frame <= 5'h00;
        end else if (since_frame != 5'h1f) begin
            since_frame <= since_frame + 5'h01;
        end
    end

    // ********************************
    // Properties
    // ********************************
    property p_rst_quiet;
        @(posedge ref_clk) disable iff (1'b0) rst |=> irq_out_n && !spi_sdio_oe;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active during reset");
    property p_irq_fall;
        $fell(irq_out_n) |-> calm < 5'h08;
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt fell without a cause");
    property p_irq_rise;
        $rose(irq_out_n) |-> since_frame < 5'h0c;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("interrupt released without a write");
    property p_cs_drop;
        $rose(spi_cs_n) |-> ##[1:6] !spi_sdio_oe;
    endproperty
    a_cs_drop: assert property (p_cs_drop)
        else $error("data driver not released after frame");
    property p_oe_idle;
        spi_cs_n [*6] |-> !spi_sdio_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle)
        else $error("data driven while not selected");
    property p_oe_frame;
        $rose(spi_sdio_oe) |-> !$past(spi_cs_n, 3);
    endproperty
    a_oe_frame: assert property (p_oe_frame)
        else $error("data driver enabled outside a frame");
    property p_oe_sclk;
        $rose(spi_sdio_oe) |-> !spi_sclk;
    endproperty
    a_oe_sclk: assert property (p_oe_sclk)
        else $error("data driver enabled with clock high");
    property p_out_sclk;
        spi_sdio_oe && $changed(spi_sdio_out) |-> !spi_sclk;
    endproperty
    a_out_sclk: assert property (p_out_sclk)
        else $error("read data changed while clock high");

    c_irq_fall: cover property ($fell(irq_out_n));
    c_irq_rise: cover property ($rose(irq_out_n));
    c_read: cover property ($rose(spi_sdio_oe));
endmodule

bind sil_top sil_top_monitor mon (.*);

/* File: testbench/tb_top.sv */
// Self-checking bench for the status and interrupt logic
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] fault = 8'h00;
    logic [1:0] selected_input_code = 2'h0;
    logic synth_calibration_active = 1'b1;
    wire spi_sclk, spi_cs_n, spi_sdio_in, spi_sdio_out, spi_sdio_oe, irq_out_n;
    wire synth_lock_loss_live_n = ~fault[5];
    wire vcxo_lock_loss_live_n = ~fault[4];
    wire [3:0] input_active_live = ~fault[3:0];
    wire reference_present_live = ~fault[7];
    wire holdover_live_n = ~fault[6];
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] ea, ev, fv, fa, fe, cv;
    // Enable reg, enable, fault, flag reg, flag read, clear
    logic [47:0] rows [8] = '{48'h68_20_20_6c_1f_20, 48'h68_10_10_6c_2f_10,
        48'h68_01_01_6c_3e_01, 48'h68_02_02_6c_3d_02, 48'h68_04_04_6c_3b_04,
        48'h68_08_08_6c_37_08, 48'h69_02_80_6e_01_02, 48'h69_01_40_6e_02_01};

    sil_top dut (.*);
    sil_host_model host (.*);

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(1'b0, a[6:0], d, x);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] x;
        host.xfer(1'b1, a[6:0], 8'h00, x);
        chk(x, e);
    endtask
    task automatic irq(input logic e);
        chk({7'h00, irq_out_n}, {7'h00, e});
    endtask
    task automatic pulse(input logic [7:0] f);
        fault = f;
        repeat (8) @(negedge ref_clk);
        fault = 8'h00;
        repeat (8) @(negedge ref_clk);
    endtask

    initial begin
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        rdc(8'h68, 8'h00);
        rdc(8'h69, 8'h00);
        irq(1'b1);
        rdc(8'h6f, 8'h07);
        rdc(8'h70, 8'h00);
        wr(8'h68, 8'hff);
        rdc(8'h68, 8'h3f);
        wr(8'h68, 8'h00);
        wr(8'h6c, 8'hff);
        wr(8'h6e, 8'h03);
        for (int r = 0; r < 8; r++) begin
            {ea, ev, fv, fa, fe, cv} = rows[r];
            wr(ea, ev);
            fault = fv;
            rdc(8'h6d, {2'b00, ~fv[5:0]});
            fault = 8'h00;
            repeat (8) @(negedge ref_clk);
            irq(1'b0);
            rdc(fa, fe);
            wr(fa, cv);
            irq(1'b1);
            wr(ea, 8'h00);
        end
        // Two enabled sources: the pin waits for the last clear
        wr(8'h68, 8'h30);
        pulse(8'h30);
        wr(8'h6c, 8'h20);
        irq(1'b0);
        wr(8'h6c, 8'h10);
        irq(1'b1);
        // A fault still present re-sets its latch over the clear
        wr(8'h68, 8'h01);
        fault = 8'h01;
        wr(8'h6c, 8'h01);
        irq(1'b0);
        rdc(8'h6c, 8'h3e);
        fault = 8'h00;
        wr(8'h6c, 8'h01);
        irq(1'b1);
        wr(8'h68, 8'h00);
        // Recovery of the reference alone must interrupt
        fault = 8'h80;
        repeat (8) @(negedge ref_clk);
        wr(8'h6e, 8'h02);
        fault = 8'h00;
        repeat (8) @(negedge ref_clk);
        rdc(8'h6e, 8'h01);
        wr(8'h69, 8'h02);
        irq(1'b0);
        wr(8'h6e, 8'h02);
        irq(1'b1);
        wr(8'h69, 8'h00);
        for (int c = 0; c < 4; c++) begin
            selected_input_code = c[1:0];
            rdc(8'h6d, {c[1:0], 6'h3f});
        end
        // Reset in mid-run drops enables and the pin
        wr(8'h68, 8'h20);
        pulse(8'h20);
        irq(1'b0);
        rst = 1'b1;
        repeat (12) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        irq(1'b1);
        rdc(8'h68, 8'h00);
        stop_test();
    end
endmodule
